/* File: src/ulev_defs.vh */
// constants for the ulpi event, receive and register logic
`ifndef ULEV_DEFS_VH
`define ULEV_DEFS_VH
// wishbone byte offsets
`define ULEV_WB_CTRL 4'h0
`define ULEV_WB_STAT 4'h4
`define ULEV_WB_ULPI 4'h8
// wishbone control fields
`define ULEV_CTRL_RXCMD_BIT 0
// ulpi command codes, data[7:6]
`define ULEV_CMD_TX 2'h1
`define ULEV_CMD_WR 2'h2
`define ULEV_CMD_RD 2'h3
`define ULEV_EXT_ADDR 6'h2F
// ulpi register addresses
`define ULEV_A_FUNC 8'h04
`define ULEV_A_INTF 8'h07
`define ULEV_A_OTG 8'h0A
`define ULEV_A_RISE 8'h0D
`define ULEV_A_FALL 8'h10
// ulpi register reset values
`define ULEV_RST_FUNC 8'h41
`define ULEV_RST_INTF 8'h00
`define ULEV_RST_OTG 8'h06
`define ULEV_RST_RISE 8'h1F
`define ULEV_RST_FALL 8'h1F
// field positions
`define ULEV_F_TERM 2
`define ULEV_F_COMPL 5
`define ULEV_F_PASS 6
`define ULEV_F_PD_PLUS 1
`define ULEV_F_PD_MINUS 2
`define ULEV_F_USE_EXT 7
// interrupt enable bit positions
`define ULEV_E_HD 0
`define ULEV_E_VV 1
`define ULEV_E_SV 2
`define ULEV_E_SE 3
// receive event codes
`define ULEV_EV_IDLE 2'h0
`define ULEV_EV_ACT 2'h1
`define ULEV_EV_DISC 2'h2
`define ULEV_EV_ERR 2'h3
`endif

/* File: src/ulev_sync2.v */
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module ulev_sync2 #(
   parameter W = 1
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire [W-1:0] i_d,
   output reg [W-1:0] o_q
);
   reg [W-1:0] meta_r;

   // first stage feeds only the second
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= {W{1'b0}};
         o_q <= {W{1'b0}};
      end else begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end
endmodule // ulev_sync2
`default_nettype wire

/* File: src/ulev_edge_evt.v */
// enabled rising and falling edge event detector
`timescale 1ns/1ps
`default_nettype none
module ulev_edge_evt #(
   parameter W = 4
) (
   input wire i_ref_clk,
   input wire i_rst,
   input wire [W-1:0] i_level,
   input wire [W-1:0] i_rise_en,
   input wire [W-1:0] i_fall_en,
   output wire [W-1:0] o_event
);
   reg [W-1:0] prev_r;

   // remember last level
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         prev_r <= {W{1'b0}};
      end else begin
         prev_r <= i_level;
      end
   end

   // event only on an enabled direction
   assign o_event = (i_level & ~prev_r & i_rise_en) | (~i_level & prev_r & i_fall_en);
endmodule // ulev_edge_evt
`default_nettype wire

/* File: src/ulev_top.v */
// ulpi transceiver event reporting, receive framing and register access
// Contract
// - send an rxcmd whenever the encoded supply state changes (here only for changes enabled in the rise and fall enable registers)
// - receive event field: 00 idle, 01 active, 11 error, 10 disconnect
// - on sync, signal receive active by dir with nxt, or rxcmd
// - on receive error drop nxt, send error rxcmd; link discards packet
// - disconnect valid only with both pulldowns; each change sends an rxcmd (here only if enabled in rise/fall enable bit 0)
// - accept immediate and extended address register reads and writes
// - dir raised during a register access aborts it; link retries
// - supply state: 00 below end, 01 end to valid, 10 valid, 11 a-valid
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "ulev_defs.vh"
module ulev_top (
   input wire i_ref_clk,
   input wire i_rst,
   // classic wishbone slave
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire i_wb_we,
   input wire [3:0] i_wb_adr,
   input wire [3:0] i_wb_sel,
   input wire [31:0] i_wb_dat,
   output reg [31:0] o_wb_dat,
   output reg o_wb_ack,
   // ulpi pins
   input wire [7:0] i_ulpi_data,
   output reg [7:0] o_ulpi_data,
   output reg o_ulpi_data_oe,
   output reg o_ulpi_dir,
   output reg o_ulpi_nxt,
   input wire i_ulpi_stp,
   // analog comparators and pins, asynchronous
   input wire i_session_end,
   input wire i_session_valid,
   input wire i_a_device_supply_valid,
   input wire i_fault,
   input wire i_host_disconnect_a,
   input wire [1:0] i_line_state,
   // receiver core, same clock
   input wire i_rx_sync,
   input wire i_rx_valid,
   input wire [7:0] i_rx_data,
   input wire i_rx_err,
   input wire i_rx_end,
   // analog controls from the register set
   output wire [1:0] o_transceiver_select,
   output wire o_termination_select,
   output wire [1:0] o_operating_mode,
   output wire o_plus_line_pulldown,
   output wire o_minus_line_pulldown
);
   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_W_CMD = 4'h1;
   localparam [3:0] S_W_EXT = 4'h2;
   localparam [3:0] S_W_DATA = 4'h3;
   localparam [3:0] S_W_STP = 4'h4;
   localparam [3:0] S_R_CMD = 4'h5;
   localparam [3:0] S_R_EXT = 4'h6;
   localparam [3:0] S_R_TURN = 4'h7;
   localparam [3:0] S_R_DATA = 4'h8;
   localparam [3:0] S_TX = 4'h9;
   localparam [3:0] S_C_TURN = 4'hA;
   localparam [3:0] S_C_SEND = 4'hB;
   localparam [3:0] S_RX_TURN = 4'hC;
   localparam [3:0] S_RX_RUN = 4'hD;
   localparam [3:0] S_BACK = 4'hE;

   reg [3:0] state_r;
   reg [7:0] func_r;
   reg [7:0] intf_r;
   reg [7:0] otg_r;
   reg [7:0] rise_irq_enable_r;
   reg [7:0] fall_irq_enable_r;
   reg [7:0] addr_r;
   reg [7:0] wdata_r;
   reg [7:0] abort_cnt_r;
   reg [7:0] last_rxcmd_r;
   reg [1:0] ls_prev_r;
   reg rxcmd_method_r;
   reg receive_active_r;
   reg receive_error_r;
   reg rx_req_r;
   reg pend_r;

   // ----------------------------------------
   // input synchronisation and supply encoding
   // ----------------------------------------
   wire [6:0] sync_q;
   wire session_end;
   wire session_valid;
   wire comp_a_valid;
   wire fault_s;
   wire host_disconnect_a;
   wire [1:0] line_state;
   wire fault_ind;
   wire a_device_supply_valid;
   reg [1:0] vbus_state;

   ulev_sync2 #(.W(7)) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_d({i_line_state, i_host_disconnect_a, i_fault, i_a_device_supply_valid,
            i_session_valid, i_session_end}),
      .o_q(sync_q)
   );
   assign session_end = sync_q[0];
   assign session_valid = sync_q[1];
   assign comp_a_valid = sync_q[2];
   assign fault_s = sync_q[3];
   assign host_disconnect_a = sync_q[4];
   assign line_state = sync_q[6:5];

   // external fault indicator replaces or qualifies the internal comparator
   assign fault_ind = fault_s ^ intf_r[`ULEV_F_COMPL];
   assign a_device_supply_valid = ~otg_r[`ULEV_F_USE_EXT] ? comp_a_valid :
                                  intf_r[`ULEV_F_PASS] ? fault_ind : (fault_ind & comp_a_valid);

   // encoded supply state
   always @* begin
      if (a_device_supply_valid) begin
         vbus_state = 2'h3;
      end else if (session_valid) begin
         vbus_state = 2'h2;
      end else if (!session_end) begin
         vbus_state = 2'h1;
      end else begin
         vbus_state = 2'h0;
      end
   end

   // ----------------------------------------
   // event detection and rxcmd byte
   // ----------------------------------------
   wire host_mode;
   wire [3:0] lvl;
   wire [3:0] edge_evt;
   wire new_evt;
   wire rc_sent;
   reg [1:0] receive_event_field;
   wire [7:0] rxcmd;

   // disconnect only counts with both pulldowns on
   assign host_mode = otg_r[`ULEV_F_PD_PLUS] & otg_r[`ULEV_F_PD_MINUS];
   assign lvl = {session_end, session_valid, a_device_supply_valid, host_disconnect_a & host_mode};

   ulev_edge_evt #(.W(4)) u_edge (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_level(lvl),
      .i_rise_en(rise_irq_enable_r[3:0]),
      .i_fall_en(fall_irq_enable_r[3:0]),
      .o_event(edge_evt)
   );

   // supply, disconnect or line change raises a pending rxcmd
   assign new_evt = (|edge_evt) | (line_state != ls_prev_r);
   assign rc_sent = (state_r == S_C_SEND) ||
                    ((state_r == S_RX_RUN) && !i_rx_end && (receive_error_r || i_rx_err || !i_rx_valid));

   // receive event encoding
   always @* begin
      if (lvl[`ULEV_E_HD] && !receive_active_r) begin
         receive_event_field = `ULEV_EV_DISC;
      end else if (receive_active_r && (receive_error_r || i_rx_err)) begin
         receive_event_field = `ULEV_EV_ERR;
      end else if (receive_active_r) begin
         receive_event_field = `ULEV_EV_ACT;
      end else begin
         receive_event_field = `ULEV_EV_IDLE;
      end
   end
   assign rxcmd = {2'h0, receive_event_field, vbus_state, line_state};

   // ----------------------------------------
   // ulpi register read mux
   // ----------------------------------------
   reg [7:0] reg_rdata;
   always @* begin
      case (addr_r)
         `ULEV_A_FUNC: reg_rdata = func_r;
         `ULEV_A_INTF: reg_rdata = intf_r;
         `ULEV_A_OTG: reg_rdata = otg_r;
         `ULEV_A_RISE: reg_rdata = rise_irq_enable_r;
         `ULEV_A_FALL: reg_rdata = fall_irq_enable_r;
         default: reg_rdata = 8'h00;
      endcase
   end

   // analog controls
   assign o_transceiver_select = func_r[1:0];
   assign o_termination_select = func_r[`ULEV_F_TERM];
   assign o_operating_mode = func_r[4:3];
   assign o_plus_line_pulldown = otg_r[`ULEV_F_PD_PLUS];
   assign o_minus_line_pulldown = otg_r[`ULEV_F_PD_MINUS];

   // ----------------------------------------
   // ulpi bus state machine
   // ----------------------------------------
   wire link_cmd;
   wire reg_busy;
   assign link_cmd = (i_ulpi_data[7:6] != 2'h0);
   assign reg_busy = (state_r == S_W_CMD) || (state_r == S_W_EXT) || (state_r == S_W_DATA) ||
                     (state_r == S_W_STP) || (state_r == S_R_CMD) || (state_r == S_R_EXT);

   // bus ownership, register access and receive framing
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= S_IDLE;
         o_ulpi_dir <= 1'b0;
         o_ulpi_nxt <= 1'b0;
         o_ulpi_data <= 8'h00;
         o_ulpi_data_oe <= 1'b0;
         func_r <= `ULEV_RST_FUNC;
         intf_r <= `ULEV_RST_INTF;
         otg_r <= `ULEV_RST_OTG;
         rise_irq_enable_r <= `ULEV_RST_RISE;
         fall_irq_enable_r <= `ULEV_RST_FALL;
         addr_r <= 8'h00;
         wdata_r <= 8'h00;
         abort_cnt_r <= 8'h00;
         last_rxcmd_r <= 8'h00;
         ls_prev_r <= 2'h0;
         receive_active_r <= 1'b0;
         receive_error_r <= 1'b0;
         rx_req_r <= 1'b0;
         pend_r <= 1'b0;
      end else begin
         ls_prev_r <= line_state;
         pend_r <= (pend_r & ~rc_sent) | new_evt;
         rx_req_r <= rx_req_r | i_rx_sync;
         if (rc_sent) begin
            last_rxcmd_r <= rxcmd;
         end
         if (i_rx_err && receive_active_r) begin
            receive_error_r <= 1'b1;
         end
         if ((rx_req_r || i_rx_sync) && (state_r == S_IDLE || reg_busy)) begin
            // sync seen in idle or a register access before the read turnaround: take the bus, abort that access
            if (reg_busy) begin
               abort_cnt_r <= abort_cnt_r + 8'h01;
            end
            rx_req_r <= 1'b0;
            receive_active_r <= 1'b1;
            receive_error_r <= 1'b0;
            o_ulpi_dir <= 1'b1;
            o_ulpi_nxt <= ~rxcmd_method_r;
            o_ulpi_data_oe <= 1'b0;
            state_r <= S_RX_TURN;
         end else begin
            case (state_r)
               S_IDLE: begin
                  o_ulpi_nxt <= 1'b0;
                  o_ulpi_data_oe <= 1'b0;
                  addr_r <= {2'h0, i_ulpi_data[5:0]};
                  if (link_cmd) begin
                     o_ulpi_nxt <= 1'b1;
                     if (i_ulpi_data[7:6] == `ULEV_CMD_WR) begin
                        state_r <= S_W_CMD;
                     end else if (i_ulpi_data[7:6] == `ULEV_CMD_RD) begin
                        state_r <= S_R_CMD;
                     end else begin
                        state_r <= S_TX;
                     end
                  end else if (pend_r) begin
                     o_ulpi_dir <= 1'b1;
                     state_r <= S_C_TURN;
                  end
               end
               S_W_CMD: begin
                  state_r <= (addr_r[5:0] == `ULEV_EXT_ADDR) ? S_W_EXT : S_W_DATA;
               end
               S_W_EXT: begin
                  addr_r <= i_ulpi_data;
                  state_r <= S_W_DATA;
               end
               S_W_DATA: begin
                  wdata_r <= i_ulpi_data;
                  o_ulpi_nxt <= 1'b0;
                  state_r <= S_W_STP;
               end
               S_W_STP: begin
                  if (i_ulpi_stp) begin
                     case (addr_r)
                        `ULEV_A_FUNC: func_r <= wdata_r;
                        `ULEV_A_INTF: intf_r <= wdata_r;
                        `ULEV_A_OTG: otg_r <= wdata_r;
                        `ULEV_A_RISE: rise_irq_enable_r <= wdata_r;
                        `ULEV_A_FALL: fall_irq_enable_r <= wdata_r;
                        default: wdata_r <= wdata_r;
                     endcase
                  end
                  state_r <= S_IDLE;
               end
               S_R_CMD: begin
                  if (addr_r[5:0] == `ULEV_EXT_ADDR) begin
                     state_r <= S_R_EXT;
                  end else begin
                     o_ulpi_nxt <= 1'b0;
                     o_ulpi_dir <= 1'b1;
                     state_r <= S_R_TURN;
                  end
               end
               S_R_EXT: begin
                  addr_r <= i_ulpi_data;
                  o_ulpi_nxt <= 1'b0;
                  o_ulpi_dir <= 1'b1;
                  state_r <= S_R_TURN;
               end
               S_R_TURN: begin
                  o_ulpi_data <= reg_rdata;
                  o_ulpi_data_oe <= 1'b1;
                  state_r <= S_R_DATA;
               end
               S_R_DATA: begin
                  o_ulpi_data_oe <= 1'b0;
                  o_ulpi_dir <= 1'b0;
                  state_r <= S_BACK;
               end
               S_TX: begin
                  // transmit path lies elsewhere; accept bytes until stop
                  o_ulpi_nxt <= ~i_ulpi_stp;
                  if (i_ulpi_stp) begin
                     state_r <= S_IDLE;
                  end
               end
               S_C_TURN: begin
                  o_ulpi_data <= rxcmd;
                  o_ulpi_data_oe <= 1'b1;
                  state_r <= S_C_SEND;
               end
               S_C_SEND: begin
                  o_ulpi_data_oe <= 1'b0;
                  o_ulpi_dir <= 1'b0;
                  state_r <= S_BACK;
               end
               S_RX_TURN: begin
                  o_ulpi_nxt <= 1'b0;
                  o_ulpi_data <= rxcmd;
                  o_ulpi_data_oe <= 1'b1;
                  state_r <= S_RX_RUN;
               end
               S_RX_RUN: begin
                  if (i_rx_end) begin
                     receive_active_r <= 1'b0;
                     o_ulpi_nxt <= 1'b0;
                     o_ulpi_data_oe <= 1'b0;
                     o_ulpi_dir <= 1'b0;
                     state_r <= S_BACK;
                  end else if (receive_error_r || i_rx_err) begin
                     o_ulpi_nxt <= 1'b0;
                     o_ulpi_data <= rxcmd;
                  end else if (i_rx_valid) begin
                     o_ulpi_nxt <= 1'b1;
                     o_ulpi_data <= i_rx_data;
                  end else begin
                     o_ulpi_nxt <= 1'b0;
                     o_ulpi_data <= rxcmd;
                  end
               end
               S_BACK: begin
                  state_r <= S_IDLE;
               end
               default: begin
                  state_r <= S_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   wire wb_req;
   assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;

   // one wait state answer, read mux and control write
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h00000000;
         rxcmd_method_r <= 1'b0;
      end else begin
         o_wb_ack <= wb_req;
         o_wb_dat <= 32'h00000000;
         if (wb_req && i_wb_we) begin
            if (i_wb_adr == `ULEV_WB_CTRL && i_wb_sel[0]) begin
               rxcmd_method_r <= i_wb_dat[`ULEV_CTRL_RXCMD_BIT];
            end
         end else if (wb_req) begin
            case (i_wb_adr)
               `ULEV_WB_CTRL: o_wb_dat <= {31'h00000000, rxcmd_method_r};
               `ULEV_WB_STAT: o_wb_dat <= {7'h00, pend_r, receive_error_r, receive_active_r,
                                          2'h0, state_r, abort_cnt_r, last_rxcmd_r};
               `ULEV_WB_ULPI: o_wb_dat <= {8'h00, intf_r, otg_r, func_r};
               default: o_wb_dat <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // ulev_top
`default_nettype wire

/* File: bench/ulev_top_chk.sv */
// assertion checker bound to the ulpi event block
`timescale 1ns/1ps
`default_nettype none
module ulev_top_chk (
   input wire i_ref_clk,
   input wire i_rst,
   input wire i_wb_cyc,
   input wire i_wb_stb,
   input wire [31:0] o_wb_dat,
   input wire o_wb_ack,
   input wire [7:0] i_ulpi_data,
   input wire o_ulpi_data_oe,
   input wire o_ulpi_dir,
   input wire o_ulpi_nxt,
   input wire i_rx_sync,
   input wire i_rx_err,
   input wire i_rx_end
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);
   // wishbone answer timing
   AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held too long");
   AST_ACK_NEXT: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
   AST_DAT_IDLE: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("read data without ack");
   // bus ownership and receive framing
   AST_OE_OWNED: assert property (o_ulpi_data_oe |-> o_ulpi_dir) else $error("data driven without dir");
   AST_RX_START: assert property (i_rx_sync |-> ##[1:8] o_ulpi_dir) else $error("no dir after sync");
   AST_ERR_NXT: assert property (o_ulpi_dir && i_rx_err |=> !o_ulpi_nxt) else $error("nxt kept on error");
   AST_RX_END: assert property (o_ulpi_dir && i_rx_end |=> !o_ulpi_dir) else $error("dir kept after end");
   AST_WR_NXT: assert property (!o_ulpi_dir && $rose(o_ulpi_nxt) && $past(i_ulpi_data[7:6]) == 2'h2
      |-> o_ulpi_nxt ##1 o_ulpi_nxt) else $error("write nxt too short");
endmodule // ulev_top_chk
bind ulev_top ulev_top_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_ulpi_data(i_ulpi_data), .o_ulpi_data_oe(o_ulpi_data_oe),
   .o_ulpi_dir(o_ulpi_dir), .o_ulpi_nxt(o_ulpi_nxt), .i_rx_sync(i_rx_sync), .i_rx_err(i_rx_err), .i_rx_end(i_rx_end));
`default_nettype wire

/* File: bench/ulev_link.sv */
// behavioural link controller on the ulpi side
`timescale 1ns/1ps
`default_nettype none
module ulev_link (
   input wire logic i_ref_clk,
   input wire logic i_dir,
   input wire logic i_nxt,
   input wire logic i_oe,
   input wire logic [7:0] i_data,
   output var logic [7:0] o_data,
   output var logic o_stp
);
   logic dir_q = 1'b0, rx_act = 1'b0, both_start = 1'b0, dropped = 1'b0, rd_busy = 1'b0;
   logic [7:0] last_cmd = 8'h00;
   int cmd_cnt = 0;
   int pkt_bytes = 0;
   int timeouts = 0;
   initial o_data = 8'h00;
   initial o_stp = 1'b0;
   // follow rxcmd bytes, packet bytes and receive framing
   always @(posedge i_ref_clk) begin
      dir_q <= i_dir;
      if (i_dir && !dir_q) begin
         both_start <= i_nxt;
         rx_act <= i_nxt;
         pkt_bytes <= 0;
         dropped <= 1'b0;
      end else if (i_dir && i_oe && !i_nxt && !rd_busy) begin
         last_cmd <= i_data;
         cmd_cnt <= cmd_cnt + 1;
         rx_act <= i_data[4];
         if (i_data[5:4] == 2'h3) dropped <= 1'b1;
      end else if (i_dir && i_nxt) pkt_bytes <= pkt_bytes + 1;
      if (!i_dir) rx_act <= 1'b0;
   end
   // register write, repeated whenever the phy takes the bus
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic ext);
      logic [7:0] b [3];
      int n, i, k;
      b[0] = 8'h80 | (ext ? 8'h2F : {2'h0, a[5:0]});
      b[1] = ext ? a : v;
      b[2] = v;
      n = ext ? 3 : 2;
      i = 0;
      @(posedge i_ref_clk) o_data <= b[0];
      for (k = 0; k < 300 && i < n; k++) begin
         @(posedge i_ref_clk);
         if (i_dir) begin
            o_data <= 8'h00;
            while (i_dir) @(posedge i_ref_clk);
            i = 0;
            @(posedge i_ref_clk) o_data <= b[0];
         end else if (i_nxt) begin
            i++;
            o_data <= (i < n) ? b[i] : 8'h00;
            o_stp <= (i == n);
         end
      end
      if (i < n) timeouts++;
      @(posedge i_ref_clk) o_stp <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
   endtask
   // register read, data taken at the edge where the phy drives it
   task automatic rd(input logic [7:0] a, input logic ext, output logic [7:0] v);
      int i, k;
      i = 0;
      rd_busy = 1'b1;
      @(posedge i_ref_clk) o_data <= 8'hC0 | (ext ? 8'h2F : {2'h0, a[5:0]});
      for (k = 0; k < 50 && !(i_dir && i_oe); k++) begin
         @(posedge i_ref_clk);
         if (i_nxt && !i_dir) begin
            i++;
            o_data <= (ext && i == 1) ? a : 8'h00;
         end
      end
      if (!(i_dir && i_oe)) timeouts++;
      v = i_data;
      @(posedge i_ref_clk);
      rd_busy = 1'b0;
      @(posedge i_ref_clk);
   endtask
endmodule // ulev_link
`default_nettype wire

/* File: bench/ulev_top_tb.sv */
// self-checking bench for the ulpi event block
`timescale 1ns/1ps
`default_nettype none
module ulev_top_tb;
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, se = 1'b1, sv = 1'b0, av = 1'b0;
   logic disc = 1'b0, rsync = 1'b0, rvalid = 1'b0, rerr = 1'b0, rend = 1'b0, fault = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic [7:0] rdata = 8'h00;
   logic [1:0] ls = 2'h0;
   wire [31:0] rdat;
   wire [7:0] ldata, pdata;
   wire [1:0] xsel, opm;
   wire ack, oe, dir, nxt, stp, term, pdp, pdm;
   int num_errors = 0;
   int check_count = 0;
   always #2.5 clk = ~clk;
   ulev_top dut (.i_ref_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
      .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_ulpi_data(ldata), .o_ulpi_data(pdata),
      .o_ulpi_data_oe(oe), .o_ulpi_dir(dir), .o_ulpi_nxt(nxt), .i_ulpi_stp(stp), .i_session_end(se),
      .i_session_valid(sv), .i_a_device_supply_valid(av), .i_fault(fault), .i_host_disconnect_a(disc),
      .i_line_state(ls), .i_rx_sync(rsync), .i_rx_valid(rvalid), .i_rx_data(rdata), .i_rx_err(rerr),
      .i_rx_end(rend), .o_transceiver_select(xsel), .o_termination_select(term), .o_operating_mode(opm),
      .o_plus_line_pulldown(pdp), .o_minus_line_pulldown(pdm));
   ulev_link link (.i_ref_clk(clk), .i_dir(dir), .i_nxt(nxt), .i_oe(oe), .i_data(pdata), .o_data(ldata), .o_stp(stp));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
      check_count++;
      if (seen !== want) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
      end
   endtask
   task automatic close_out;
      if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // classic wishbone cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk);
      if (ack !== 1'b1) num_errors++;
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wait_cmd;
      int c, k;
      c = link.cmd_cnt;
      for (k = 0; k < 60 && link.cmd_cnt == c; k++) @(posedge clk);
      repeat (12) @(posedge clk);
   endtask
   task automatic t_reset;
      logic [31:0] q;
      check("xcvr_sel", xsel, 2'h1);
      check("op_mode", {term, opm}, 3'h0);
      check("pulldowns", {pdp, pdm}, 2'h3);
      wb(1'b1, 4'hC, 32'hFFFF_FFFF, q);
      wb(1'b0, 4'hC, 32'h0, q);
      check("wb_unmapped", q, 32'h0);
      wb(1'b0, 4'h8, 32'h0, q);
      check("wb_mirror", q, 32'h0000_0641);
   endtask
   task automatic t_regs;
      logic [7:0] v;
      link.wr(8'h04, 8'h50, 1'b0);
      check("chirp_ctrl", {xsel, term, opm}, 5'h02);
      link.rd(8'h04, 1'b0, v);
      check("func_rd", v, 8'h50);
      link.wr(8'h0D, 8'h0E, 1'b1);
      link.rd(8'h0D, 1'b1, v);
      check("rise_ext", v, 8'h0E);
      link.rd(8'h3A, 1'b1, v);
      check("unmapped_rd", v, 8'h00);
      link.wr(8'h0D, 8'h1F, 1'b0);
      link.wr(8'h04, 8'h41, 1'b0);
   endtask
   task automatic t_supply;
      logic [2:0] tbl [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
      logic [1:0] ev [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      int i, c;
      for (i = 0; i < 4; i++) begin
         c = link.cmd_cnt;
         @(posedge clk) {se, sv, av} <= tbl[i];
         wait_cmd;
         check("supply_cmd", link.cmd_cnt > c, 1'b1);
         check("supply_code", link.last_cmd[3:2], ev[i]);
      end
      link.wr(8'h0D, 8'h00, 1'b0);
      link.wr(8'h10, 8'h00, 1'b0);
      c = link.cmd_cnt;
      @(posedge clk) se <= 1'b0;
      wait_cmd;
      check("masked", link.cmd_cnt, c);
      link.wr(8'h0D, 8'h1F, 1'b0);
      link.wr(8'h10, 8'h1F, 1'b0);
      @(posedge clk) se <= 1'b1;
      wait_cmd;
      check("supply_code", link.last_cmd[3:2], 2'h0);
      check("supply_cmd", link.cmd_cnt > c, 1'b1);
   endtask
   task automatic t_disc;
      int c;
      @(posedge clk) disc <= 1'b1;
      wait_cmd;
      check("disc_code", link.last_cmd[5:4], 2'h2);
      @(posedge clk) disc <= 1'b0;
      wait_cmd;
      check("disc_clear", link.last_cmd[5:4], 2'h0);
      link.wr(8'h0A, 8'h00, 1'b0);
      c = link.cmd_cnt;
      @(posedge clk) disc <= 1'b1;
      wait_cmd;
      check("disc_ignored", link.cmd_cnt, c);
      @(posedge clk) disc <= 1'b0;
      wait_cmd;
      link.wr(8'h0A, 8'h06, 1'b0);
   endtask
   // sync lands while a register write is in flight
   task automatic t_abort;
      logic [31:0] q;
      fork
         link.wr(8'h07, 8'h20, 1'b0);
         begin
            repeat (2) @(posedge clk);
            rsync <= 1'b1;
            @(posedge clk) rsync <= 1'b0;
            repeat (4) @(posedge clk);
            rend <= 1'b1;
            @(posedge clk) rend <= 1'b0;
         end
      join
      wb(1'b0, 4'h4, 32'h0, q);
      check("abort_count", q[15:8], 8'h01);
      wb(1'b0, 4'h8, 32'h0, q);
      check("retried_write", q[23:16], 8'h20);
   endtask
   task automatic t_rx(input logic m);
      logic [31:0] q;
      int k;
      wb(1'b1, 4'h0, {31'h0, m}, q);
      @(posedge clk) rsync <= 1'b1;
      @(posedge clk) rsync <= 1'b0;
      repeat (2) @(posedge clk);
      for (k = 0; k < 3; k++) begin
         rvalid <= 1'b1;
         rdata <= 8'hA0 + k[7:0];
         @(posedge clk);
      end
      rvalid <= 1'b0;
      repeat (3) @(posedge clk);
      check("start_method", link.both_start, !m);
      check("rx_bytes", link.pkt_bytes, 3);
      check("rx_event", {link.rx_act, link.last_cmd[5:4]}, 3'h5);
      rerr <= 1'b1;
      @(posedge clk) rerr <= 1'b0;
      repeat (3) @(posedge clk);
      check("err_event", {link.dropped, link.last_cmd[5:4]}, 3'h7);
      rend <= 1'b1;
      @(posedge clk) rend <= 1'b0;
      repeat (3) @(posedge clk);
      check("rx_closed", {dir, link.rx_act}, 2'h0);
   endtask
   // external fault pin stands in for the a-device comparator, line change rides along
   task automatic t_fault;
      link.wr(8'h07, 8'h40, 1'b0);
      link.wr(8'h0A, 8'h86, 1'b0);
      @(posedge clk) {fault, ls} <= 3'h5;
      wait_cmd;
      check("fault_cmd", link.last_cmd, 8'h0D);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (40) @(posedge clk);
      t_reset;
      t_regs;
      t_supply;
      t_disc;
      t_abort;
      t_rx(1'b0);
      t_rx(1'b1);
      t_fault;
      check("link_timeouts", link.timeouts, 0);
      close_out;
   end
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      close_out;
   end
endmodule // ulev_top_tb
`default_nettype wire
